// file: acs_cfg.svh
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// ------------------------------------------------------------
// Register map (byte addresses on the 32-bit bus)
// ------------------------------------------------------------
`define ACS_CTRL_INDEX 8'hCB
`define ACS_CTRL_ADDR 10'h32C
`define ACS_RESULT_ADDR 10'h330
`define ACS_STATUS_ADDR 10'h334
`define ACS_CTRL_RESET 8'h00
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ACS_BUSY_BIT 0
`define ACS_PSC_LSB 1
`define ACS_MODE_LSB 3
`define ACS_CH_LSB 5
// ------------------------------------------------------------
// Timing in converter cycles; prescaler divisors in input cycles
// ------------------------------------------------------------
`define ACS_RESET_CYC 4'd1
`define ACS_SAMPLE_CYC 4'd7
`define ACS_CONV_CYC 4'd8
`define ACS_LOAD_CYC 4'd1
`define ACS_DESEL_CYC 4'd1
`define ACS_DIV2 4'd2
`define ACS_DIV4 4'd4
`define ACS_DIV6 4'd6
`define ACS_DIV12 4'd12
`endif

// file: acs_pkg.sv
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_SE_SINGLE,
    ACS_SE_SCAN,
    ACS_DIFF_SINGLE,
    ACS_DIFF_SCAN
  } acs_mode_t;
  typedef enum logic [2:0] {
    ACS_IDLE,
    ACS_RESET,
    ACS_SAMPLE,
    ACS_CONVERT,
    ACS_LOAD,
    ACS_DESELECT
  } acs_state_t;
endpackage

// file: acs_sequencer.sv
`include "acs_cfg.svh"
module acs_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Power state of the device
  input wire logic low_power_i,
  // Analog core
  input wire logic cmp_i,
  output logic conv_power_o,
  output logic conv_clk_o,
  output logic sample_o,
  output logic conv_select_o,
  output logic [7:0] pos_sel_o,
  output logic [7:0] neg_sel_o,
  output logic diff_mode_o,
  output logic [7:0] dac_code_o
);
  import acs_pkg::*;

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic [2:0] channel;
  acs_mode_t mode;
  logic [1:0] psc;
  logic busy;
  logic [7:0] result;
  logic result_valid;
  acs_state_t state;
  logic [3:0] phase_cnt;
  logic [3:0] div_cnt;
  logic [3:0] div_val;
  logic half_tick;
  logic tick_rise;
  logic tick_fall;
  logic cclk;
  logic [7:0] sar;
  logic [2:0] bit_idx;
  logic restart_pend;
  logic lp_q;
  logic wr_ctrl;
  logic rd_hit;
  logic ctrl_hit;
  logic res_hit;
  logic stat_hit;
  logic done_single;
  logic frame_start;
  logic continuous;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign ctrl_hit = wb_adr_i == `ACS_CTRL_ADDR;
  assign res_hit = wb_adr_i == `ACS_RESULT_ADDR;
  assign stat_hit = wb_adr_i == `ACS_STATUS_ADDR;
  assign wr_ctrl = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && ctrl_hit && wb_sel_i[0];
  assign rd_hit = ctrl_hit || res_hit || stat_hit;
  assign continuous = mode == ACS_SE_SCAN || mode == ACS_DIFF_SCAN;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Read data registered so a load mid-read cannot tear the word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
      if (ctrl_hit) begin
        wb_dat_o <= {24'h00_0000, channel, mode, psc, busy};
      end else if (res_hit) begin
        wb_dat_o <= {24'h00_0000, result};
      end else if (stat_hit) begin
        wb_dat_o <= {29'h0000_0000, conv_power_o, restart_pend, result_valid};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  // Frozen fields while busy keep a running frame consistent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel <= 3'h0;
      mode <= ACS_SE_SINGLE;
      psc <= 2'h0;
    end else if (wr_ctrl && !busy) begin
      channel <= wb_dat_i[`ACS_CH_LSB +: 3];
      mode <= acs_mode_t'(wb_dat_i[`ACS_MODE_LSB +: 2]);
      psc <= wb_dat_i[`ACS_PSC_LSB +: 2];
    end
  end

  // Software write wins over the hardware clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
    end else if (wr_ctrl) begin
      busy <= wb_dat_i[`ACS_BUSY_BIT];
    end else if (done_single) begin
      busy <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  always_comb begin
    case (psc)
      2'h0: div_val = `ACS_DIV2;
      2'h1: div_val = `ACS_DIV4;
      2'h2: div_val = `ACS_DIV6;
      default: div_val = `ACS_DIV12;
    endcase
  end

  // Converter clock toggles every div_val/2 input cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy || low_power_i) begin
      div_cnt <= 4'h0;
      cclk <= 1'b0;
    end else if (half_tick) begin
      div_cnt <= 4'h0;
      cclk <= !cclk;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  assign half_tick = busy && !low_power_i && (div_cnt == ((div_val >> 1) - 4'h1));
  assign tick_rise = half_tick && !cclk;
  assign tick_fall = half_tick && cclk;
  assign conv_clk_o = cclk;
  assign conv_power_o = busy && !low_power_i;

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  assign done_single = tick_fall && state == ACS_LOAD && !continuous && !wr_ctrl;
  assign frame_start = wr_ctrl && wb_dat_i[`ACS_BUSY_BIT] && !busy;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_q <= 1'b0;
    end else begin
      lp_q <= low_power_i;
    end
  end

  // A frame cut by low power reruns on exit and is flagged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_pend <= 1'b0;
    end else if (frame_start) begin
      restart_pend <= 1'b0;
    end else if (low_power_i && !lp_q && busy) begin
      restart_pend <= 1'b1;
    end else if (state == ACS_LOAD && tick_fall) begin
      restart_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !busy || low_power_i) begin
      state <= ACS_IDLE;
      phase_cnt <= 4'h0;
    end else if (tick_fall) begin
      case (state)
        ACS_IDLE: begin
          state <= ACS_RESET;
          phase_cnt <= 4'h0;
        end
        ACS_RESET: begin
          state <= ACS_SAMPLE;
          phase_cnt <= `ACS_SAMPLE_CYC - 4'h1;
        end
        ACS_SAMPLE: begin
          if (phase_cnt == 4'h0) begin
            state <= ACS_CONVERT;
            phase_cnt <= `ACS_CONV_CYC - 4'h1;
          end else begin
            phase_cnt <= phase_cnt - 4'h1;
          end
        end
        ACS_CONVERT: begin
          if (phase_cnt == 4'h0) begin
            state <= ACS_LOAD;
          end else begin
            phase_cnt <= phase_cnt - 4'h1;
          end
        end
        ACS_LOAD: begin
          state <= continuous ? ACS_DESELECT : ACS_IDLE;
        end
        ACS_DESELECT: begin
          state <= ACS_SAMPLE;
          phase_cnt <= `ACS_SAMPLE_CYC - 4'h1;
        end
        default: state <= ACS_IDLE;
      endcase
    end
  end

  // Gated by power so the switch opens at once on low-power entry
  assign sample_o = state == ACS_SAMPLE && conv_power_o;
  assign conv_select_o = state != ACS_IDLE && state != ACS_DESELECT;

  // ------------------------------------------------------------
  // Successive approximation
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sar <= 8'h00;
      bit_idx <= 3'h7;
    end else if (tick_fall && state == ACS_SAMPLE && phase_cnt == 4'h0) begin
      sar <= 8'h80;
      bit_idx <= 3'h7;
    end else if (tick_rise && state == ACS_CONVERT) begin
      sar[bit_idx] <= cmp_i;
      if (bit_idx != 3'h0) begin
        sar[bit_idx - 3'h1] <= 1'b1;
        bit_idx <= bit_idx - 3'h1;
      end
    end
  end
  assign dac_code_o = sar;

  // Whole-byte load in one edge; reads see old or new, never a mix
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_valid <= 1'b0;
    end else if (tick_fall && state == ACS_LOAD) begin
      result_valid <= !restart_pend;
    end else if (frame_start) begin
      result_valid <= 1'b0;
    end
  end

  // Cleared on reset only to keep the read-only check free of unknowns
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= 8'h00;
    end else if (tick_fall && state == ACS_LOAD) begin
      result <= sar;
    end
  end

  // ------------------------------------------------------------
  // Input routing
  // ------------------------------------------------------------
  assign diff_mode_o = mode == ACS_DIFF_SINGLE || mode == ACS_DIFF_SCAN;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_route
      assign pos_sel_o[g] = conv_power_o && channel == 3'(g);
      assign neg_sel_o[g] = conv_power_o && diff_mode_o && (channel ^ 3'h1) == 3'(g);
    end
  endgenerate

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_busy_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl |=> busy == $past(wb_dat_i[0]);
  endproperty
  a_busy_write: assert property (p_busy_write) else $error("busy not written");

  property p_frozen;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && busy) |=> $stable(channel) && $stable(mode) && $stable(psc);
  endproperty
  a_frozen: assert property (p_frozen) else $error("field changed while busy");

  property p_idle_off;
    @(posedge clk_i) disable iff (rst_i)
      !busy |=> !cclk && state == ACS_IDLE;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("clock runs while idle");

  sequence s_sample_end;
    tick_fall && state == ACS_SAMPLE && phase_cnt == 4'h0;
  endsequence
  property p_sample_to_convert;
    @(posedge clk_i) disable iff (rst_i)
      s_sample_end ##1 busy && !low_power_i |-> state == ACS_CONVERT;
  endproperty
  a_sample_to_convert: assert property (p_sample_to_convert) else $error("bad phase");

  property p_single_done;
    @(posedge clk_i) disable iff (rst_i)
      done_single |=> !busy && !conv_power_o;
  endproperty
  a_single_done: assert property (p_single_done) else $error("busy kept");

  property p_scan_keep;
    @(posedge clk_i) disable iff (rst_i)
      (state == ACS_LOAD && tick_fall && continuous && !wr_ctrl) |=> busy;
  endproperty
  a_scan_keep: assert property (p_scan_keep) else $error("scan dropped busy");

  property p_result_ro;
    @(posedge clk_i) disable iff (rst_i)
      !(tick_fall && state == ACS_LOAD) |=> $stable(result);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result changed");

  property p_lp_down;
    @(posedge clk_i) disable iff (rst_i)
      low_power_i |-> !conv_power_o && !sample_o;
  endproperty
  a_lp_down: assert property (p_lp_down) else $error("powered in low power");
endmodule

// file: acs_analog_model.sv
module acs_analog_model (
  // Clock
  input wire logic clk_i,
  // Sequencer side
  input wire logic power_i,
  input wire logic [7:0] pos_sel_i,
  input wire logic [7:0] dac_code_i,
  input wire logic [63:0] chan_v_i,
  output logic cmp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] vin;
  logic idle_tgl = 1'b0;
  always_ff @(posedge clk_i) begin
    idle_tgl <= ~idle_tgl;
  end
  // Negative leg is held steady, so only the positive input matters
  always_comb begin
    vin = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (pos_sel_i[i]) begin
        vin = chan_v_i[i*8 +: 8];
      end
    end
  end
  // Unpowered core gives no usable decision
  assign cmp_o = power_i ? (vin >= dac_code_i) : idle_tgl;
endmodule

// file: adc_control_sequencer_tb.sv
`include "acs_cfg.svh"
module adc_control_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import acs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic low_power_i = 1'b0;
  logic [63:0] chan_v_i = 64'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, cmp_i, conv_power_o, conv_clk_o, sample_o, conv_select_o, diff_mode_o;
  logic [7:0] pos_sel_o, neg_sel_o, dac_code_o, ps, ns;
  logic dm;
  logic [31:0] exp_q[$], msk_q[$];
  int n_errors = 0;
  int total_checks = 0;
  int n, s;
  int dvs[4] = '{`ACS_DIV2, `ACS_DIV4, `ACS_DIV6, `ACS_DIV12};
  acs_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_power_i(low_power_i), .cmp_i(cmp_i),
    .conv_power_o(conv_power_o), .conv_clk_o(conv_clk_o), .sample_o(sample_o),
    .conv_select_o(conv_select_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o),
    .diff_mode_o(diff_mode_o), .dac_code_o(dac_code_o));
  acs_analog_model core (.clk_i(clk_i), .power_i(conv_power_o), .pos_sel_i(pos_sel_o),
    .dac_code_i(dac_code_o), .chan_v_i(chan_v_i), .cmp_o(cmp_i));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Read data is judged by the watcher, oldest note first
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      chk("read data", exp_q[0] & msk_q[0], wb_dat_o & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // For a read, d is the expected value under mask m
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= we ? d : 32'h0;
    if (!we) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (wb_ack_o !== 1'b1) begin
      chk("ack", 1, 0);
      summarize();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Waits out a frame, counting powered and sampling cycles
  task automatic wait_idle;
    n = 0;
    s = 0;
    while (conv_power_o === 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
      if (sample_o === 1'b1) begin
        s++;
        ps = pos_sel_o;
        ns = neg_sel_o;
        dm = diff_mode_o;
      end
    end
    if (conv_power_o === 1'b1) begin
      chk("idle wait", 1, 0);
      summarize();
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] c;
    int dv, fl, sn;
    void'($urandom(59526));
    chan_v_i <= {$urandom, $urandom};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `ACS_CTRL_ADDR, 32'h0, 32'hFF);
    chk("power", 0, conv_power_o);
    for (int m = 0; m < 3; m += 2) begin
      for (int ch = 0; ch < 8; ch++) begin
        // Only divide by 6 or 12 keeps the converter clock in range
        dv = dvs[2 + ch % 2];
        c = {ch[2:0], m[1:0], 2'(2 + ch % 2), 1'b1};
        wb(1, `ACS_CTRL_ADDR, {24'h0, c}, 0);
        wait_idle();
        chk("sample cycles", 7 * dv, s);
        chk("frame", 1, (n >= 17 * dv && n <= 19 * dv));
        chk("pos sel", 8'h01 << ch, ps);
        chk("neg sel", m ? 8'h01 << (ch ^ 1) : 8'h00, ns);
        chk("diff mode", m >> 1, dm);
        if (m == 0) wb(0, `ACS_RESULT_ADDR, chan_v_i[ch*8 +: 8], 32'hFF);
        wb(0, `ACS_CTRL_ADDR, c & 8'hFE, 32'hFF);
      end
    end
    chk("conv clock", 0, conv_clk_o);
    // Last frame converted positive channel 7
    wb(1, `ACS_RESULT_ADDR, ~chan_v_i[63:56], 0);
    wb(0, `ACS_RESULT_ADDR, chan_v_i[63:56], 32'hFF);
    wb(0, 10'h000, 32'h0, 32'hFFFFFFFF);
    wb(1, `ACS_CTRL_ADDR, 32'hAD, 0);
    wb(1, `ACS_CTRL_ADDR, 32'h57, 0);
    wb(0, `ACS_CTRL_ADDR, 32'hAD, 32'hFF);
    // Count idle-select cycles only once sampling was seen
    fl = 0;
    sn = 0;
    repeat (120) begin
      @(negedge clk_i);
      if (sample_o === 1'b1) sn = 1;
      if (sn == 1 && conv_select_o === 1'b0 && conv_power_o === 1'b1) fl++;
    end
    chk("deselect cycles", `ACS_DIV6 * `ACS_DESEL_CYC, fl);
    wb(0, `ACS_CTRL_ADDR, 32'hAD, 32'hFF);
    // Stop then start in consecutive writes
    wb(1, `ACS_CTRL_ADDR, 32'hAC, 0);
    wb(1, `ACS_CTRL_ADDR, 32'hAD, 0);
    chk("power", 1, conv_power_o);
    wb(1, `ACS_CTRL_ADDR, 32'hAC, 0);
    chk("power", 0, conv_power_o);
    wb(1, `ACS_CTRL_ADDR, 32'h05, 0);
    repeat (10) @(posedge clk_i);
    low_power_i <= 1'b1;
    @(negedge clk_i);
    chk("power", 0, conv_power_o);
    repeat (10) @(posedge clk_i);
    low_power_i <= 1'b0;
    @(negedge clk_i);
    wait_idle();
    chk("rerun frame", 1, n >= 17 * `ACS_DIV6 && n <= 19 * `ACS_DIV6);
    wb(0, `ACS_STATUS_ADDR, 32'h0, 32'h1);
    // Reset in the middle of a running frame
    wb(1, `ACS_CTRL_ADDR, 32'h05, 0);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("power", 0, conv_power_o);
    chk("dac code", 0, dac_code_o);
    wb(0, `ACS_CTRL_ADDR, 32'h0, 32'hFF);
    summarize();
  end
endmodule
